// ===== design/wcm_reset_src.sv
// Watchdog counter and loop clock monitor, the two reset sources.
// Assumes a plain register port on the same clock and that stop_mode_i
// comes from the power controller on this clock; clock pins and the
// oscillator status are asynchronous and are synchronised here.
//
// Notes on behaviour
// - Loop clock stopped or too slow raises the loop monitor reset.
// - Full stop mode switches the loop monitor off; no reset then.
// - Enabled watchdog reaching time-out without restart raises reset.
// - Watchdog ticks come from aux, internal reference or oscillator.
// - Aux source with stop disable resynchronises after stop exit.
// - High select: count on aux in stop unless stop disable is set.
// - Low side counts in stop only with all oscillator run bits set.
// - Other low side cases freeze in stop; source osc or internal.
`timescale 1ns/1ns
`default_nettype none
module wcm_reset_src
  import wcm_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              aux_clk_i,
  input  wire logic              irc_clk_i,
  input  wire logic              osc_clk_i,
  input  wire logic              pll_clk_i,
  input  wire logic              osc_up_i,
  input  wire logic              stop_mode_i,
  output logic                   pll_mon_reset_o,
  output logic                   wdog_reset_o,
  output logic                   sys_reset_req_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // State
  wcm_ctrl_t         ctrl_q;
  logic [15:0]       timeout_q;
  logic [15:0]       cnt_q;
  logic [15:0]       cnt_d;
  wcm_key_t          key_q;
  wcm_key_t          key_d;
  logic [2:0]        resync_q;
  logic [2:0]        resync_d;
  logic              stop_q;
  logic [7:0]        pll_cnt_q;
  logic [7:0]        pll_cnt_d;
  logic              up1_q;
  logic              up2_q;
  logic [IRQ_W-1:0]  int_st_q;
  logic [IRQ_W-1:0]  int_st_d;
  logic [IRQ_W-1:0]  int_en_q;
  logic              pll_rst_q;
  logic              wd_rst_q;
  logic              sys_rst_q;
  logic              irq_q;
  logic [DATA_W-1:0] rdata_q;
  logic [N_TICK-1:0] tick;

  ////////////////////////////////////////////////////////////////////////
  // Clock pins become tick enables on the one system clock
  wcm_edge_tick #(
    .N (N_TICK)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({pll_clk_i, osc_clk_i, irc_clk_i, aux_clk_i}),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_ctrl    = wr_i & (addr_i == OFS_CTRL);
  wire wr_timeout = wr_i & (addr_i == OFS_TIMEOUT);
  wire wr_restart = wr_i & (addr_i == OFS_RESTART);
  wire wr_int_clr = wr_i & (addr_i == OFS_INT_CLR);
  wire wr_int_en  = wr_i & (addr_i == OFS_INT_EN);
  wire [7:0] wkey = wdata_i[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Clock source selection and stop behaviour
  wire sel_hi   = ctrl_q.watchdog_clk_sel_high;
  wire osc_ok   = ctrl_q.watchdog_clk_sel_low &
                  ctrl_q.oscillator_enable & up2_q;
  wire aux_tick = tick[TK_AUX];
  wire irc_tick = tick[TK_IRC];
  wire osc_tick = tick[TK_OSC];
  wire pll_tick = tick[TK_PLL];
  // Aux when high select; else oscillator only when fully up
  wire src_tick = sel_hi ? aux_tick :
                  (osc_ok ? osc_tick : irc_tick);
  // Aux keeps running in stop only without the stop disable bit
  wire hi_run   = ~ctrl_q.aux_clock_stop_disable;
  wire lo_run   = ctrl_q.pseudo_stop_enable &
                  ctrl_q.watchdog_stop_run_enable & osc_ok;
  wire stop_run = sel_hi ? hi_run : lo_run;
  wire full_stop = stop_mode_i & ~ctrl_q.pseudo_stop_enable;
  wire stop_exit = stop_q & ~stop_mode_i;

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counting
  // A frozen aux domain needs a few of its own ticks before the
  // counter may trust the tick stream again after stop.
  wire resync_go   = stop_exit & sel_hi &
                     ctrl_q.aux_clock_stop_disable;
  wire resync_busy = (resync_q != 3'h0);
  wire restart     = wr_restart & (wkey == KEY_FIRE) &
                     (key_q == WCM_KEY_ARMED);
  wire cnt_gate    = ctrl_q.wd_en & ~wd_rst_q & ~resync_busy &
                     (~stop_mode_i | stop_run);
  wire cnt_adv     = cnt_gate & src_tick & ~restart;
  // Counts 0 to timeout, so time-out is timeout plus one ticks
  wire wd_expire   = cnt_adv & (cnt_q >= timeout_q);

  ////////////////////////////////////////////////////////////////////////
  // Loop clock monitor
  // A gap of LOOP_FAIL_CYC cycles means stopped or below threshold
  wire mon_on   = ctrl_q.pll_mon_en & ~full_stop;
  wire pll_fail = mon_on & ~pll_tick &
                  (pll_cnt_q == LOOP_FAIL_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  wire [DATA_W-1:0] st_word = DATA_W'({wd_rst_q, pll_rst_q,
                              resync_busy, cnt_gate,
                              stop_mode_i, up2_q});
  wire [DATA_W-1:0] rd_mux =
    (addr_i == OFS_CTRL)    ? DATA_W'(ctrl_q)   :
    (addr_i == OFS_TIMEOUT) ? timeout_q         :
    (addr_i == OFS_STATUS)  ? st_word           :
    (addr_i == OFS_COUNT)   ? cnt_q             :
    (addr_i == OFS_INT_ST)  ? DATA_W'(int_st_q) :
    (addr_i == OFS_INT_EN)  ? DATA_W'(int_en_q) :
                              16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Next-state terms
  always_comb begin
    cnt_d = cnt_q;
    if (~ctrl_q.wd_en || restart) begin
      cnt_d = 16'h0000;
    end else if (cnt_adv && ~wd_expire) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // Restart needs the arm key, then the fire key
  always_comb begin
    key_d = key_q;
    if (wr_restart) begin
      case (key_q)
        WCM_KEY_IDLE: begin
          key_d = (wkey == KEY_ARM) ? WCM_KEY_ARMED : WCM_KEY_IDLE;
        end
        WCM_KEY_ARMED: begin
          key_d = (wkey == KEY_ARM) ? WCM_KEY_ARMED : WCM_KEY_IDLE;
        end
        default: begin
          key_d = WCM_KEY_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    resync_d = resync_q;
    if (resync_go) begin
      resync_d = AUX_SYNC_TICKS;
    end else if (resync_busy && aux_tick) begin
      resync_d = resync_q - 3'h1;
    end
  end

  // Monitor counter restarts on each rising loop clock edge
  always_comb begin
    pll_cnt_d = pll_cnt_q;
    if (~mon_on || pll_tick) begin
      pll_cnt_d = 8'h00;
    end else if (pll_cnt_q != LOOP_FAIL_LAST) begin
      pll_cnt_d = pll_cnt_q + 8'h01;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign int_st_d = (int_st_q & ~(wr_int_clr ? wdata_i[IRQ_W-1:0] :
                    {IRQ_W{1'b0}})) | {wd_expire, pll_fail};

  ////////////////////////////////////////////////////////////////////////
  // Software registers and synchroniser for oscillator status
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q    <= CTRL_RST;
      timeout_q <= TIMEOUT_RST;
      int_en_q  <= {IRQ_W{1'b0}};
      up1_q     <= 1'b0;
      up2_q     <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= wcm_ctrl_t'(wdata_i[7:0]);
      if (wr_timeout) timeout_q <= wdata_i;
      if (wr_int_en) int_en_q <= wdata_i[IRQ_W-1:0];
      up1_q <= osc_up_i;
      up2_q <= up1_q;
    end
  end

  // Counters and sequence state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q     <= 16'h0000;
      key_q     <= WCM_KEY_IDLE;
      resync_q  <= 3'h0;
      stop_q    <= 1'b0;
      pll_cnt_q <= 8'h00;
      int_st_q  <= {IRQ_W{1'b0}};
    end else begin
      cnt_q     <= cnt_d;
      key_q     <= key_d;
      resync_q  <= resync_d;
      stop_q    <= stop_mode_i;
      pll_cnt_q <= pll_cnt_d;
      int_st_q  <= int_st_d;
    end
  end

  // Reset requests hold until the system reset clears this block
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pll_rst_q <= 1'b0;
      wd_rst_q  <= 1'b0;
      sys_rst_q <= 1'b0;
      irq_q     <= 1'b0;
      rdata_q   <= 16'h0000;
    end else begin
      pll_rst_q <= pll_rst_q | pll_fail;
      wd_rst_q  <= wd_rst_q | wd_expire;
      sys_rst_q <= sys_rst_q | pll_fail | wd_expire;
      irq_q     <= |(int_st_d & int_en_q);
      rdata_q   <= rd_i ? rd_mux : 16'h0000;
    end
  end

  assign pll_mon_reset_o = pll_rst_q;
  assign wdog_reset_o    = wd_rst_q;
  assign sys_reset_req_o = sys_rst_q;
  assign irq_o           = irq_q;
  assign rdata_o         = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_loop_fail_reset: assert property (
    (mon_on && !pll_tick && pll_cnt_q == LOOP_FAIL_LAST)
      |=> pll_mon_reset_o && int_st_q[IRQ_PLL])
    else $error("loop monitor failure did not raise reset");

  a_full_stop_quiet: assert property (
    (stop_mode_i && !ctrl_q.pseudo_stop_enable && !pll_mon_reset_o)
      |=> !pll_mon_reset_o)
    else $error("loop monitor reset raised in full stop");

  a_wdog_timeout: assert property (
    (cnt_adv && cnt_q >= timeout_q) |=> wdog_reset_o ##1 wdog_reset_o)
    else $error("watchdog time-out did not raise reset");

  a_src_aux_sel: assert property (
    ctrl_q.watchdog_clk_sel_high |-> (src_tick == tick[TK_AUX]))
    else $error("watchdog not ticking on aux clock");

  a_aux_resync_hold: assert property (
    (stop_q && !stop_mode_i && ctrl_q.watchdog_clk_sel_high &&
     ctrl_q.aux_clock_stop_disable)
      |=> !cnt_adv [*2])
    else $error("watchdog counted during aux resync");

  a_aux_stop_run: assert property (
    (stop_mode_i && ctrl_q.watchdog_clk_sel_high)
      |-> (cnt_gate == (ctrl_q.wd_en && !wd_rst_q && !resync_busy &&
           !ctrl_q.aux_clock_stop_disable)))
    else $error("aux stop behaviour wrong");

  a_osc_stop_run: assert property (
    (stop_mode_i && !ctrl_q.watchdog_clk_sel_high && lo_run &&
     ctrl_q.wd_en && !wd_rst_q && !resync_busy && tick[TK_OSC] &&
     !restart && cnt_q < timeout_q)
      |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("watchdog frozen while oscillator run set");

  a_low_side_static: assert property (
    (stop_mode_i && !ctrl_q.watchdog_clk_sel_high && !lo_run &&
     ctrl_q.wd_en && !restart) |=> $stable(cnt_q))
    else $error("watchdog moved in static stop case");

  a_src_osc_sel: assert property (
    (!ctrl_q.watchdog_clk_sel_high && !osc_ok)
      |-> (src_tick == tick[TK_IRC]))
    else $error("internal reference not selected");

  a_sys_reset_feed: assert property (
    ($rose(wdog_reset_o) || $rose(pll_mon_reset_o))
      |-> sys_reset_req_o ##1 sys_reset_req_o)
    else $error("reset source did not reach system request");

  // Interrupt follows next status, so an event in the same cycle as a clear wins
  a_irq_level: assert property (
    (int_st_d[IRQ_WD] && int_en_q[IRQ_WD]) |=> irq_o)
    else $error("enabled status did not raise interrupt");

  a_irq_drop: assert property (
    !(|(int_st_d & int_en_q)) |=> !irq_o)
    else $error("interrupt high without enabled status");

  // Requests are sticky until the common reset clears this block
  a_wdog_sticky: assert property (
    wdog_reset_o |=> wdog_reset_o)
    else $error("watchdog reset request dropped");

  a_loop_sticky: assert property (
    pll_mon_reset_o |=> pll_mon_reset_o)
    else $error("loop monitor reset request dropped");

  a_sys_from_src: assert property (
    sys_reset_req_o |-> (wdog_reset_o || pll_mon_reset_o))
    else $error("system request without a reset source");

  a_wd_off_clear: assert property (
    !ctrl_q.wd_en |=> (cnt_q == 16'h0000))
    else $error("disabled watchdog counter not cleared");

  a_src_osc_pick: assert property (
    (!ctrl_q.watchdog_clk_sel_high && osc_ok)
      |-> (src_tick == tick[TK_OSC]))
    else $error("oscillator not selected when fully up");

  // Monitor off must not carry a stale gap count into the next enable
  a_mon_off_hold: assert property (
    !mon_on |=> (pll_cnt_q == 8'h00))
    else $error("loop monitor counted while off");

endmodule
`default_nettype wire

// ===== design/wcm_pkg.sv
// Constants and types of the watchdog and loop clock monitor reset block.
// Assumes one 125 MHz clock; all other clocks arrive as sampled pins.
package wcm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_RESTART = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_COUNT   = 8'h10;
  localparam logic [7:0] OFS_INT_ST  = 8'h14;
  localparam logic [7:0] OFS_INT_CLR = 8'h18;
  localparam logic [7:0] OFS_INT_EN  = 8'h1C;

  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [15:0] TIMEOUT_RST = 16'hFFFF;
  localparam logic [7:0]  KEY_ARM     = 8'h55;
  localparam logic [7:0]  KEY_FIRE    = 8'hAA;

  // Status register bit positions
  localparam int ST_OSC_UP = 0;
  localparam int ST_STOP   = 1;
  localparam int ST_RUN    = 2;
  localparam int ST_RESYNC = 3;
  localparam int ST_PLLRST = 4;
  localparam int ST_WDRST  = 5;

  // Interrupt bit positions
  localparam int IRQ_PLL = 0;
  localparam int IRQ_WD  = 1;
  localparam int IRQ_W   = 2;

  ////////////////////////////////////////////////////////////////////////
  // Clock pins sampled as tick pulses
  localparam int TK_AUX = 0;
  localparam int TK_IRC = 1;
  localparam int TK_OSC = 2;
  localparam int TK_PLL = 3;
  localparam int N_TICK = 4;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  // Loop clock failure threshold, plain default
  localparam int LOOP_FAIL_KHZ = 1000;
  localparam int LOOP_FAIL_NS  = 1000000 / LOOP_FAIL_KHZ;
  // Longest allowed gap between loop clock edges, rounded up
  localparam int LOOP_FAIL_CYC =
    (LOOP_FAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LOOP_FAIL_LAST = 8'(LOOP_FAIL_CYC - 1);
  // Aux clock ticks spent resynchronising after stop exit
  localparam logic [2:0] AUX_SYNC_TICKS = 3'h3;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic pll_mon_en;
    logic oscillator_enable;
    logic watchdog_stop_run_enable;
    logic pseudo_stop_enable;
    logic aux_clock_stop_disable;
    logic watchdog_clk_sel_high;
    logic watchdog_clk_sel_low;
    logic wd_en;
  } wcm_ctrl_t;

  typedef enum logic {
    WCM_KEY_IDLE,
    WCM_KEY_ARMED
  } wcm_key_t;

endpackage

// ===== design/wcm_edge_tick.sv
// Turns slow clock pins into one-cycle tick pulses on the fast clock.
// Assumes each pin runs well below half of the fast clock rate.
`timescale 1ns/1ns
`default_nettype none
module wcm_edge_tick
  import wcm_pkg::*;
#(
  parameter int N = N_TICK
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] pin_i,
  output logic      [N-1:0] tick_o
);

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser, then rising edge detect per pin
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic tk_q;
      // First stage feeds only the second stage
      // Stages reset high so a pin resting high gives no false edge;
      // a real rise in the first cycles after reset may be missed
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          tk_q <= 1'b0;
        end else begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          tk_q <= s2_q & ~s3_q;
        end
      end
      assign tick_o[g] = tk_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== sim/wcm_reset_src_test.sv
// Self-checking bench for the watchdog and loop clock monitor reset block.
// Assumes the register port of wcm_reset_src and its clock pin sampling.
`timescale 1ns/1ns
`default_nettype none
module wcm_reset_src_test
  import wcm_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic [ADDR_W-1:0] addr_i    = '0;
  logic [DATA_W-1:0] wdata_i   = '0;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic [2:0]        ck        = '0;
  logic              pll_clk   = 1'b0;
  logic              pll_run   = 1'b0;
  logic              osc_up    = 1'b0;
  logic              stop      = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic              pll_rst;
  logic              wd_rst;
  logic              sys_rst;
  logic              irq_o;
  int                error_cnt = 0;
  int                compares  = 0;
  int                cycles    = 0;

  wcm_reset_src dut_u (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .aux_clk_i      (ck[TK_AUX]),
    .irc_clk_i      (ck[TK_IRC]),
    .osc_clk_i      (ck[TK_OSC]),
    .pll_clk_i      (pll_clk),
    .osc_up_i       (osc_up),
    .stop_mode_i    (stop),
    .pll_mon_reset_o(pll_rst),
    .wdog_reset_o   (wd_rst),
    .sys_reset_req_o(sys_rst),
    .irq_o          (irq_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock, cycle ceiling and a loop clock well above the failure rate
  always #4 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  always begin
    repeat (4) @(posedge ref_clk_i);
    if (pll_run) pll_clk <= ~pll_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Access and comparison tasks
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Read data stands only in the cycle after the strobe; it is taken
  // at the edge that closes that cycle, before the edge updates it
  task automatic rc(input logic [7:0] a, input logic [15:0] exp,
                    input string nm);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(nm, rdata_o, exp);
  endtask

  // Slow pin pulses; each leaves time for the tick to land inside
  task automatic tk(input int k, input int n);
    repeat (n) begin
      ck[k] <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      ck[k] <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask

  task automatic rst_pulse();
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rc(OFS_CTRL, 16'h0000, "ctrl");
    rc(OFS_TIMEOUT, 16'hFFFF, "timeout");
    rc(OFS_INT_EN, 16'h0000, "int_en");
    rc(OFS_RESTART, 16'h0000, "restart");
    rc(8'h20, 16'h0000, "unmapped");
    // Watchdog on the internal reference, restart keys, time-out
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_TIMEOUT, 16'h0002);
    wr(OFS_INT_EN, 16'h0002);
    tk(TK_AUX, 1);
    tk(TK_OSC, 1);
    rc(OFS_COUNT, 16'h0000, "count other src");
    tk(TK_IRC, 2);
    rc(OFS_COUNT, 16'h0002, "count irc");
    wr(OFS_RESTART, 16'h0055);
    wr(OFS_RESTART, 16'h00AA);
    rc(OFS_COUNT, 16'h0000, "count restart");
    tk(TK_IRC, 2);
    wr(OFS_RESTART, 16'h0055);
    wr(OFS_RESTART, 16'h0013);
    wr(OFS_RESTART, 16'h00AA);
    rc(OFS_COUNT, 16'h0002, "count bad key");
    chk("wdog early", wd_rst, 1'b0);
    tk(TK_IRC, 1);
    chk("wdog", wd_rst, 1'b1);
    chk("sys wdog", sys_rst, 1'b1);
    chk("irq", irq_o, 1'b1);
    rc(OFS_STATUS, 16'h0020, "status wdog");
    rc(OFS_INT_ST, 16'h0002, "int_st");
    wr(OFS_INT_CLR, 16'h0002);
    rc(OFS_INT_ST, 16'h0000, "int_st clr");
    chk("irq clr", irq_o, 1'b0);
    // Source choice and stop behaviour on the low select side
    rst_pulse();
    osc_up <= 1'b1;
    wr(OFS_CTRL, 16'h0043);
    tk(TK_OSC, 1);
    tk(TK_IRC, 1);
    rc(OFS_COUNT, 16'h0001, "osc source");
    osc_up <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    tk(TK_OSC, 1);
    tk(TK_IRC, 1);
    rc(OFS_COUNT, 16'h0002, "irc fallback");
    osc_up <= 1'b1;
    stop   <= 1'b1;
    wr(OFS_CTRL, 16'h0073);
    tk(TK_OSC, 1);
    rc(OFS_COUNT, 16'h0003, "stop run osc");
    wr(OFS_CTRL, 16'h0063);
    tk(TK_OSC, 1);
    tk(TK_IRC, 1);
    rc(OFS_COUNT, 16'h0003, "stop static");
    // High select: aux runs in stop unless stop disable, then resync
    wr(OFS_CTRL, 16'h0005);
    tk(TK_AUX, 1);
    rc(OFS_COUNT, 16'h0004, "aux stop run");
    wr(OFS_CTRL, 16'h000D);
    tk(TK_AUX, 1);
    rc(OFS_COUNT, 16'h0004, "aux stop static");
    stop <= 1'b0;
    tk(TK_AUX, 3);
    rc(OFS_COUNT, 16'h0004, "aux resync");
    tk(TK_AUX, 1);
    rc(OFS_COUNT, 16'h0005, "aux resumed");
    // Loop monitor: healthy, full stop, pseudo stop, then stuck clock
    rst_pulse();
    pll_run <= 1'b1;
    wr(OFS_CTRL, 16'h0080);
    repeat (300) @(posedge ref_clk_i);
    chk("loop healthy", pll_rst, 1'b0);
    pll_run <= 1'b0;
    stop    <= 1'b1;
    repeat (300) @(posedge ref_clk_i);
    chk("loop full stop", pll_rst, 1'b0);
    chk("sys full stop", sys_rst, 1'b0);
    wr(OFS_CTRL, 16'h0090);
    repeat (200) @(posedge ref_clk_i);
    chk("loop pseudo", pll_rst, 1'b1);
    rst_pulse();
    stop <= 1'b0;
    wr(OFS_CTRL, 16'h0080);
    wr(OFS_INT_EN, 16'h0001);
    repeat (100) @(posedge ref_clk_i);
    chk("loop not yet", pll_rst, 1'b0);
    repeat (60) @(posedge ref_clk_i);
    chk("loop stuck", pll_rst, 1'b1);
    chk("sys loop", sys_rst, 1'b1);
    chk("wdog idle", wd_rst, 1'b0);
    chk("irq loop", irq_o, 1'b1);
    rc(OFS_STATUS, 16'h0011, "status loop");
    rc(OFS_INT_ST, 16'h0001, "int_st loop");
    results();
  end
endmodule
`default_nettype wire
